// ---- hw/swire_cfg.svh ----
`ifndef SWIRE_CFG_SVH
`define SWIRE_CFG_SVH

`define SW_CLK_MHZ 100
`define SW_RST_LOW_US 500
`define SW_RST_DETECT_US 480
`define SW_PRES_FROM_US 15
`define SW_PRES_WIN_US 480
`define SW_PRES_DLY_US 30
`define SW_PRES_LOW_US 120
`define SW_INIT_US 2
`define SW_SAMPLE_US 13
`define SW_SLOT_US 62
`define SW_REC_US 3
`define SW_HOLD_US 30
`define SW_WSAMPLE_US 30
`define SW_SLOT_END_US 45
`define SW_CONV_US 1000
`define SW_SCRATCH_BYTES 9
`define SW_CRC_POLY 8'h8C
`define SW_BYTE_BITS 4'h8

`endif

// ---- hw/swire_pkg.sv ----
package swire_pkg;

  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_WRITE = 3'h1,
    OP_READ = 3'h2,
    OP_READ_BIT = 3'h3,
    OP_PULLUP = 3'h4
  } op_t;

  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_RST_LOW = 5'h02,
    M_RST_WAIT = 5'h04,
    M_SLOT = 5'h08,
    M_PULLUP = 5'h10
  } master_state_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_PWAIT = 4'h2,
    S_PLOW = 4'h4,
    S_SLOT = 4'h8
  } sensor_state_t;

endpackage

// ---- hw/swire_if.sv ----
interface swire_if;
  logic m_out;
  logic m_oe;
  logic s_out;
  logic s_oe;
  logic line;

  // open drain: any enabled low driver wins, otherwise pulled high
  assign line = !((m_oe && !m_out) || (s_oe && !s_out));

  modport master (input line, output m_out, output m_oe);
  modport sensor (input line, output s_out, output s_oe);
endinterface

// ---- hw/sensor_end.sv ----
`include "swire_cfg.svh"

module sensor_end
  import swire_pkg::*;
#(
  parameter int unsigned RST_DET_CYC = `SW_RST_DETECT_US * `SW_CLK_MHZ,
  parameter int unsigned PRES_LOW_CYC = `SW_PRES_LOW_US * `SW_CLK_MHZ,
  parameter int unsigned SLOT_END_CYC = `SW_SLOT_END_US * `SW_CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  swire_if.sensor bus,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic status_mode_in,
  input wire logic op_done_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic reset_seen_out
);
  localparam int unsigned PRES_DLY_CYC = `SW_PRES_DLY_US * `SW_CLK_MHZ;
  localparam int unsigned HOLD_CYC = `SW_HOLD_US * `SW_CLK_MHZ;
  localparam int unsigned WSAMPLE_CYC = `SW_WSAMPLE_US * `SW_CLK_MHZ;

  sensor_state_t state_reg;
  logic sync1_reg, line_reg, prev_reg;
  logic [31:0] low_cnt_reg, timer_reg;
  logic rst_seen_reg, slot_tx_reg, slot_rd_reg;
  logic [7:0] tx_shift_reg, rx_shift_reg;
  logic [3:0] tx_cnt_reg, rx_cnt_reg;
  logic start_pres, fall, slot_done, load;

  assign start_pres = rst_seen_reg && line_reg;
  assign fall = prev_reg && !line_reg && state_reg == S_IDLE;
  assign slot_done = state_reg == S_SLOT && timer_reg >= SLOT_END_CYC - 1
                     && line_reg;
  assign load = tx_ready_out && tx_valid_in;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_reg <= 1'b1;
      line_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else if (ce_in) begin
      sync1_reg <= bus.line;
      line_reg <= sync1_reg;
      prev_reg <= line_reg;
    end
  end

  // long low spell seen, acted on at the release edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_cnt_reg <= 32'h0;
      rst_seen_reg <= 1'b0;
    end else if (ce_in) begin
      if (line_reg) begin
        low_cnt_reg <= 32'h0;
      end else if (low_cnt_reg < RST_DET_CYC) begin
        low_cnt_reg <= low_cnt_reg + 32'h1;
      end
      if (start_pres) begin
        rst_seen_reg <= 1'b0;
      end else if (!line_reg && low_cnt_reg >= RST_DET_CYC - 1) begin
        rst_seen_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= S_IDLE;
      timer_reg <= 32'h0;
      bus.s_oe <= 1'b0;
      bus.s_out <= 1'b0;
      slot_tx_reg <= 1'b0;
      slot_rd_reg <= 1'b0;
      reset_seen_out <= 1'b0;
    end else if (ce_in) begin
      reset_seen_out <= 1'b0;
      timer_reg <= timer_reg + 32'h1;
      if (start_pres) begin
        state_reg <= S_PWAIT;
        timer_reg <= 32'h0;
        bus.s_oe <= 1'b0;
        reset_seen_out <= 1'b1;
      end else begin
        case (state_reg)
          S_IDLE: begin
            timer_reg <= 32'h0;
            if (fall) begin
              // bit driven only inside a slot the master opened
              state_reg <= S_SLOT;
              slot_tx_reg <= tx_cnt_reg != 4'h0;
              slot_rd_reg <= tx_cnt_reg != 4'h0 || status_mode_in;
              if (tx_cnt_reg != 4'h0) begin
                bus.s_oe <= !tx_shift_reg[0];
              end else if (status_mode_in) begin
                bus.s_oe <= !op_done_in;
              end
            end
          end
          S_PWAIT: begin
            if (timer_reg == PRES_DLY_CYC - 1) begin
              state_reg <= S_PLOW;
              timer_reg <= 32'h0;
              bus.s_oe <= 1'b1;
            end
          end
          S_PLOW: begin
            if (timer_reg == PRES_LOW_CYC - 1) begin
              state_reg <= S_IDLE;
              bus.s_oe <= 1'b0;
            end
          end
          S_SLOT: begin
            // hold well past 15us after the edge, release before 60us
            if (timer_reg == HOLD_CYC - 1) begin
              bus.s_oe <= 1'b0;
            end
            if (slot_done) begin
              state_reg <= S_IDLE;
            end
          end
          default: begin
            state_reg <= S_IDLE;
            bus.s_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // transmit byte, loaded only between bytes so a slot never changes source
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_shift_reg <= 8'h00;
      tx_cnt_reg <= 4'h0;
      tx_ready_out <= 1'b1;
    end else if (ce_in) begin
      if (start_pres) begin
        tx_cnt_reg <= 4'h0;
        tx_ready_out <= 1'b1;
      end else if (load) begin
        tx_shift_reg <= tx_data_in;
        tx_cnt_reg <= `SW_BYTE_BITS;
        tx_ready_out <= 1'b0;
      end else if (slot_done && slot_tx_reg) begin
        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
        tx_cnt_reg <= tx_cnt_reg - 4'h1;
        tx_ready_out <= tx_cnt_reg == 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_shift_reg <= 8'h00;
      rx_cnt_reg <= 4'h0;
      rx_data_out <= 8'h00;
      rx_valid_out <= 1'b0;
    end else if (ce_in) begin
      rx_valid_out <= 1'b0;
      if (start_pres) begin
        rx_cnt_reg <= 4'h0;
      end else if (state_reg == S_SLOT && !slot_rd_reg
                   && timer_reg == WSAMPLE_CYC - 1) begin
        rx_shift_reg <= {line_reg, rx_shift_reg[7:1]};
        if (rx_cnt_reg == `SW_BYTE_BITS - 4'h1) begin
          rx_cnt_reg <= 4'h0;
          rx_data_out <= {line_reg, rx_shift_reg[7:1]};
          rx_valid_out <= 1'b1;
        end else begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule

// ---- hw/master_end.sv ----
`include "swire_cfg.svh"

module master_end
  import swire_pkg::*;
#(
  parameter int unsigned RST_LOW_CYC = `SW_RST_LOW_US * `SW_CLK_MHZ,
  parameter int unsigned PRES_WIN_CYC = `SW_PRES_WIN_US * `SW_CLK_MHZ,
  parameter int unsigned SLOT_CYC = `SW_SLOT_US * `SW_CLK_MHZ,
  parameter int unsigned CONV_CYC = `SW_CONV_US * `SW_CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  swire_if.master bus,
  input wire logic cmd_valid_in,
  input wire op_t cmd_op_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_valid_out,
  input wire logic rsp_ready_in,
  output logic presence_out,
  output logic no_device_out,
  output logic crc_ok_out,
  output logic crc_bad_out
);
  localparam int unsigned INIT_CYC = `SW_INIT_US * `SW_CLK_MHZ;
  localparam int unsigned SAMPLE_CYC = `SW_SAMPLE_US * `SW_CLK_MHZ;
  localparam int unsigned REC_CYC = `SW_REC_US * `SW_CLK_MHZ;
  localparam int unsigned PRES_FROM_CYC = `SW_PRES_FROM_US * `SW_CLK_MHZ;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                           input logic [7:0] data);
    logic [7:0] c;
    logic [7:0] d;
    c = crc;
    d = data;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[0]) begin
        c = {1'b0, c[7:1]} ^ `SW_CRC_POLY;
      end else begin
        c = {1'b0, c[7:1]};
      end
      d = {1'b0, d[7:1]};
    end
    return c;
  endfunction

  master_state_t state_reg;
  logic sync1_reg, line_reg;
  logic [31:0] timer_reg;
  logic [7:0] shift_reg, push_data_reg, spare_reg, crc_reg;
  logic [3:0] bits_reg, nbytes_reg;
  logic is_read_reg, is_bit_reg, pres_seen_reg, abort_reg;
  logic push_reg, push_byte_reg, spare_v_reg;
  logic take, pop, low_long;

  assign take = cmd_valid_in && cmd_ready_out && state_reg == M_IDLE;
  assign pop = rsp_valid_out && rsp_ready_in;
  assign low_long = !is_read_reg && !shift_reg[0];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_reg <= 1'b1;
      line_reg <= 1'b1;
    end else if (ce_in) begin
      sync1_reg <= bus.line;
      line_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= M_IDLE;
      timer_reg <= 32'h0;
      bus.m_oe <= 1'b0;
      bus.m_out <= 1'b0;
      shift_reg <= 8'h00;
      bits_reg <= 4'h0;
      is_read_reg <= 1'b0;
      is_bit_reg <= 1'b0;
      pres_seen_reg <= 1'b0;
      abort_reg <= 1'b0;
      presence_out <= 1'b0;
      no_device_out <= 1'b0;
      cmd_ready_out <= 1'b0;
      push_reg <= 1'b0;
      push_byte_reg <= 1'b0;
      push_data_reg <= 8'h00;
    end else if (ce_in) begin
      push_reg <= 1'b0;
      timer_reg <= timer_reg + 32'h1;
      // no new command while the answer buffer has no room
      cmd_ready_out <= state_reg == M_IDLE && !take && !spare_v_reg;
      case (state_reg)
        M_IDLE: begin
          timer_reg <= 32'h0;
          if (take) begin
            shift_reg <= cmd_data_in;
            is_read_reg <= cmd_op_in == OP_READ || cmd_op_in == OP_READ_BIT;
            is_bit_reg <= cmd_op_in == OP_READ_BIT;
            bits_reg <= cmd_op_in == OP_READ_BIT ? 4'h1 : `SW_BYTE_BITS;
            if (cmd_op_in == OP_RESET) begin
              state_reg <= M_RST_LOW;
              bus.m_oe <= 1'b1;
              bus.m_out <= 1'b0;
              pres_seen_reg <= 1'b0;
              abort_reg <= 1'b0;
            end else if (abort_reg) begin
              state_reg <= M_IDLE;
            end else if (cmd_op_in == OP_PULLUP) begin
              state_reg <= M_PULLUP;
              bus.m_oe <= 1'b1;
              bus.m_out <= 1'b1;
            end else begin
              // data ops may follow back to back, as the read sequence needs
              state_reg <= M_SLOT;
              bus.m_oe <= 1'b1;
              bus.m_out <= 1'b0;
            end
          end
        end
        M_RST_LOW: begin
          if (timer_reg == RST_LOW_CYC - 1) begin
            state_reg <= M_RST_WAIT;
            timer_reg <= 32'h0;
            bus.m_oe <= 1'b0;
          end
        end
        M_RST_WAIT: begin
          if (timer_reg >= PRES_FROM_CYC && !line_reg) begin
            pres_seen_reg <= 1'b1;
          end
          if (timer_reg == PRES_WIN_CYC - 1) begin
            state_reg <= M_IDLE;
            presence_out <= pres_seen_reg;
            no_device_out <= !pres_seen_reg;
            abort_reg <= !pres_seen_reg;
          end
        end
        M_SLOT: begin
          // short opening low keeps the sample late in the valid window
          if (!low_long && timer_reg == INIT_CYC - 1) begin
            bus.m_oe <= 1'b0;
          end
          if (low_long && timer_reg == SLOT_CYC - 1) begin
            bus.m_oe <= 1'b0;
          end
          if (is_read_reg && timer_reg == SAMPLE_CYC - 1) begin
            shift_reg <= {line_reg, shift_reg[7:1]};
            if (bits_reg == 4'h1) begin
              push_reg <= 1'b1;
              push_byte_reg <= !is_bit_reg;
              push_data_reg <= is_bit_reg ? {7'h00, line_reg}
                                          : {line_reg, shift_reg[7:1]};
            end
          end
          if (timer_reg == SLOT_CYC + REC_CYC - 1) begin
            timer_reg <= 32'h0;
            if (!is_read_reg) begin
              shift_reg <= {1'b0, shift_reg[7:1]};
            end
            if (bits_reg == 4'h1) begin
              state_reg <= M_IDLE;
            end else begin
              bits_reg <= bits_reg - 4'h1;
              bus.m_oe <= 1'b1;
            end
          end
        end
        M_PULLUP: begin
          if (timer_reg == CONV_CYC - 1) begin
            state_reg <= M_IDLE;
            bus.m_oe <= 1'b0;
            bus.m_out <= 1'b0;
          end
        end
        default: begin
          state_reg <= M_IDLE;
          bus.m_oe <= 1'b0;
          bus.m_out <= 1'b0;
        end
      endcase
    end
  end

  // two-entry answer buffer: head drives the outputs, spare takes overflow
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_data_out <= 8'h00;
      rsp_valid_out <= 1'b0;
      spare_reg <= 8'h00;
      spare_v_reg <= 1'b0;
    end else if (ce_in) begin
      if (pop && spare_v_reg) begin
        rsp_data_out <= spare_reg;
        spare_reg <= push_data_reg;
        spare_v_reg <= push_reg;
      end else if (pop) begin
        rsp_data_out <= push_data_reg;
        rsp_valid_out <= push_reg;
      end else if (push_reg && !rsp_valid_out) begin
        rsp_data_out <= push_data_reg;
        rsp_valid_out <= 1'b1;
      end else if (push_reg) begin
        spare_reg <= push_data_reg;
        spare_v_reg <= 1'b1;
      end
    end
  end

  // remainder over all nine bytes is zero exactly when the check byte matches
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      crc_reg <= 8'h00;
      nbytes_reg <= 4'h0;
      crc_ok_out <= 1'b0;
      crc_bad_out <= 1'b0;
    end else if (ce_in) begin
      crc_ok_out <= 1'b0;
      crc_bad_out <= 1'b0;
      if (take && cmd_op_in == OP_RESET) begin
        crc_reg <= 8'h00;
        nbytes_reg <= 4'h0;
      end else if (push_reg && push_byte_reg) begin
        if (nbytes_reg == `SW_SCRATCH_BYTES - 1) begin
          crc_reg <= 8'h00;
          nbytes_reg <= 4'h0;
          crc_ok_out <= crc8_step(crc_reg, push_data_reg) == 8'h00;
          crc_bad_out <= crc8_step(crc_reg, push_data_reg) != 8'h00;
        end else begin
          crc_reg <= crc8_step(crc_reg, push_data_reg);
          nbytes_reg <= nbytes_reg + 4'h1;
        end
      end
    end
  end
endmodule

// ---- sim/swire_sva.sv ----
module swire_sva #(
  parameter int unsigned SLOT_CYC = 3300,
  parameter int unsigned CONV_CYC = 100
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic m_out,
  input wire logic m_oe,
  input wire logic s_out,
  input wire logic s_oe,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mlow, pu, zero_slot_reg;
  int unsigned hi_reg, mlo_reg, rel_reg, open_reg, soe_reg, pu_reg;
  assign mlow = m_oe && !m_out;
  assign pu = m_oe && m_out;

  // saturate so a long idle never wraps into a short gap
  function automatic int unsigned bump(input logic c, input int unsigned n);
    return !c ? 0 : (n == 32'hFFFF ? n : n + 1);
  endfunction

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hi_reg <= 0;
      mlo_reg <= 0;
      rel_reg <= 32'hFFFF;
      open_reg <= 32'hFFFF;
      soe_reg <= 0;
      pu_reg <= 0;
      zero_slot_reg <= 1'h0;
    end else begin
      hi_reg <= bump(line, hi_reg);
      mlo_reg <= bump(mlow, mlo_reg);
      rel_reg <= bump(!mlow, rel_reg);
      open_reg <= bump(!(mlow && rel_reg != 0), open_reg);
      soe_reg <= bump(s_oe, soe_reg);
      pu_reg <= bump(pu, pu_reg);
      if (s_oe && soe_reg == 0) begin
        zero_slot_reg <= mlow;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence seq_open;
    !mlow ##1 mlow;
  endsequence
  sequence seq_zero_end;
    s_oe ##1 !s_oe;
  endsequence

  AST_SENSOR_IN_SLOT: assert property (
    $rose(s_oe) |-> mlow || (hi_reg >= 1500 && hi_reg <= 6000))
    else $error("sensor drove outside slot or presence window");
  AST_ZERO_LOW: assert property (s_oe |-> !s_out && !line)
    else $error("sensor zero did not pull the line low");
  AST_ZERO_VALID: assert property (
    seq_zero_end |-> !zero_slot_reg || soe_reg >= 1500)
    else $error("sensor zero held under 15us");
  AST_ZERO_RELEASED: assert property (seq_open |-> !s_oe)
    else $error("sensor still low when next slot opened");
  AST_INIT_MIN: assert property ($fell(mlow) |-> mlo_reg >= 100)
    else $error("master low pulse under 1us");
  AST_PULSE_SHAPE: assert property (
    $fell(mlow) |-> mlo_reg <= 300 || mlo_reg >= SLOT_CYC - 1)
    else $error("master low pulse neither short nor full slot");
  AST_RECOVERY: assert property ($rose(mlow) |-> rel_reg >= 100)
    else $error("recovery between slots under 1us");
  AST_SLOT_PERIOD: assert property ($rose(mlow) |-> open_reg >= SLOT_CYC)
    else $error("slot shorter than its length");
  AST_PULLUP_HOLD: assert property (
    $fell(pu) |-> pu_reg >= CONV_CYC - 1 && !s_oe)
    else $error("strong pull-up ended early");
endmodule

// ---- sim/test_single_wire_read_slot_and_transaction.sv ----
module test_single_wire_read_slot_and_transaction
  import swire_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // write-zero low must stay under reset detection, hence the long reset
  localparam int unsigned RST_LOW = 5000;
  localparam int unsigned SLOT = 3300;
  localparam int unsigned CONV = 100;
  // about 84k cycles of traffic expected, ceiling keeps a hang short
  localparam int LIMIT = 100000;
  logic clk_in, resetn_in, m_ce, s_ce, cmd_valid_in, cmd_ready_out;
  logic rsp_valid_out, rsp_ready_in, presence_out, no_device_out;
  logic crc_ok_out, crc_bad_out, tx_valid_in, tx_ready_out;
  logic status_mode_in, op_done_in, rx_valid_out, reset_seen_out, watch;
  logic [7:0] cmd_data_in, rsp_data_out, tx_data_in, rx_data_out, d;
  op_t cmd_op_in;
  int fails, checks, cyc, rst_seen, crc_cnt;
  int unsigned seed;
  logic [7:0] exp_q[$];
  logic [7:0] rx_q[$];
  logic wire_q[$];

  swire_if u_swire_if();
  master_end #(.RST_LOW_CYC(RST_LOW), .PRES_WIN_CYC(4000),
    .SLOT_CYC(SLOT), .CONV_CYC(CONV)) u_master_end (
    .clk_in, .resetn_in, .ce_in(m_ce), .bus(u_swire_if.master),
    .cmd_valid_in, .cmd_op_in, .cmd_data_in, .cmd_ready_out,
    .rsp_data_out, .rsp_valid_out, .rsp_ready_in, .presence_out,
    .no_device_out, .crc_ok_out, .crc_bad_out);
  sensor_end #(.RST_DET_CYC(4000), .PRES_LOW_CYC(400),
    .SLOT_END_CYC(3100)) u_sensor_end (
    .clk_in, .resetn_in, .ce_in(s_ce), .bus(u_swire_if.sensor),
    .tx_data_in, .tx_valid_in, .tx_ready_out, .status_mode_in,
    .op_done_in, .rx_data_out, .rx_valid_out, .reset_seen_out);
  swire_sva #(.SLOT_CYC(SLOT), .CONV_CYC(CONV)) u_swire_sva (
    .clk_in, .resetn_in, .m_out(u_swire_if.m_out), .m_oe(u_swire_if.m_oe),
    .s_out(u_swire_if.s_out), .s_oe(u_swire_if.s_oe),
    .line(u_swire_if.line));

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic issue(input op_t op, input logic [7:0] v);
    @(posedge clk_in);
    cmd_op_in <= op;
    cmd_data_in <= v;
    cmd_valid_in <= 1'h1;
    do @(posedge clk_in); while (cmd_ready_out !== 1'h1);
    cmd_valid_in <= 1'h0;
  endtask

  task automatic idle();
    do @(posedge clk_in); while (cmd_ready_out !== 1'h1);
  endtask

  task automatic pop();
    @(posedge clk_in);
    rsp_ready_in <= 1'h1;
    do @(posedge clk_in);
    while (rsp_valid_out !== 1'h1 || rsp_ready_in !== 1'h1);
    chk(rsp_data_out, exp_q.pop_front());
    rsp_ready_in <= 1'h0;
  endtask

  task automatic wire_chk(input logic [7:0] v);
    logic [7:0] got;
    got = 8'h00;
    for (int i = 0; i < 8; i++) begin
      got[i] = wire_q[i];
    end
    chk(8'(wire_q.size()), 8'h08);
    chk(got, v);
    wire_q.delete();
  endtask

  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (reset_seen_out === 1'h1) rst_seen++;
    if (rx_valid_out === 1'h1) rx_q.push_back(rx_data_out);
    if (crc_ok_out === 1'h1 || crc_bad_out === 1'h1) crc_cnt++;
    if (cyc == LIMIT) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  // mid-slot sample of the wire, independent of either end
  always @(negedge u_swire_if.line) begin
    if (watch) begin
      repeat (1400) @(posedge clk_in);
      wire_q.push_back(u_swire_if.line);
    end
  end

  initial begin
    resetn_in = 1'h0;
    m_ce = 1'h1;
    s_ce = 1'h0;
    cmd_valid_in = 1'h0;
    cmd_op_in = OP_RESET;
    cmd_data_in = 8'h00;
    rsp_ready_in = 1'h0;
    tx_data_in = 8'h00;
    tx_valid_in = 1'h0;
    status_mode_in = 1'h0;
    op_done_in = 1'h0;
    watch = 1'h0;
    seed = $urandom(10864);
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'h1;
    // sensor frozen: no presence, later commands go nowhere
    issue(OP_RESET, 8'h00);
    idle();
    chk({6'h00, no_device_out, presence_out}, 8'h02);
    watch = 1'h1;
    issue(OP_READ_BIT, 8'h00);
    idle();
    repeat (500) @(posedge clk_in);
    chk({7'h00, rsp_valid_out}, 8'h00);
    chk(8'(wire_q.size()), 8'h00);
    watch = 1'h0;
    s_ce <= 1'h1;
    issue(OP_RESET, 8'h00);
    idle();
    chk({6'h00, no_device_out, presence_out}, 8'h01);
    chk(8'(rst_seen), 8'h01);
    watch = 1'h1;
    d = 8'($urandom);
    issue(OP_WRITE, d);
    idle();
    chk(8'(rx_q.size()), 8'h01);
    chk(rx_q.pop_front(), d);
    wire_chk(d);
    d = 8'($urandom);
    tx_data_in <= d;
    tx_valid_in <= 1'h1;
    do @(posedge clk_in); while (tx_ready_out !== 1'h1);
    tx_valid_in <= 1'h0;
    exp_q.push_back(d);
    issue(OP_READ, 8'h00);
    idle();
    pop();
    wire_chk(d);
    watch = 1'h0;
    // two status polls with the reader stalled fill the answer buffer
    status_mode_in <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      op_done_in <= i[0];
      exp_q.push_back({7'h00, i[0]});
      issue(OP_READ_BIT, 8'h00);
      if (i == 0) idle();
    end
    repeat (SLOT + 600) @(posedge clk_in);
    chk({7'h00, cmd_ready_out}, 8'h00);
    pop();
    pop();
    status_mode_in <= 1'h0;
    issue(OP_PULLUP, 8'h00);
    idle();
    chk(8'(crc_cnt), 8'h00);
    test_done();
  end
endmodule
